// >>> rpt_pkg.sv
// shared constants, types and helpers for the direction-sensing repeater control
package rpt_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int GAP_TIME_NS   = 200;
  // least time: round up to whole cycles, never below one
  localparam int GAP_CYC_RAW   = (GAP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int GAP_CYC       = (GAP_CYC_RAW < 1) ? 1 : GAP_CYC_RAW;
  localparam int IDLE_QUAL_CYC = 8;
  localparam int CNT_W         = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    RPT_IDLE,
    RPT_GAP,
    RPT_M2S,
    RPT_S2M,
    RPT_HOLD
  } rpt_state_t;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic rpt_both_idle(input logic actA, input logic actB);
    return !actA && !actB;
  endfunction : rpt_both_idle

endpackage : rpt_pkg

// >>> rpt_sense_if.sv
// qualified line activity passed from a sense channel to the direction control
`timescale 1ns/1ps
interface rpt_sense_if;
  logic active;
  modport src (output active);
  modport dst (input  active);
endinterface : rpt_sense_if

// >>> rpt_sense.sv
// one line-sense channel: synchroniser, and-combine, idle qualification
`timescale 1ns/1ps
module rpt_sense
  import rpt_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_QUAL_CYC
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic trueIn,
  input  wire logic compIn,
  rpt_sense_if.src  sense
);

  localparam int CW = $clog2(IDLE_CYC + 1);

  logic          trueS1_ff;
  logic          compS1_ff;
  logic          trueS2_ff;
  logic          compS2_ff;
  logic          active_ff;
  logic [CW-1:0] idleCnt_ff;
  logic          idleRaw;

  // ---------------------------------------------------------------
  // synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      trueS1_ff <= 1'h1;
      compS1_ff <= 1'h1;
      trueS2_ff <= 1'h1;
      compS2_ff <= 1'h1;
    end else begin
      trueS1_ff <= trueIn;  // RULE_12
      compS1_ff <= compIn;
      trueS2_ff <= trueS1_ff;
      compS2_ff <= compS1_ff;
    end
  end

  // high only when both receivers sit on the idle bias
  assign idleRaw = trueS2_ff & compS2_ff;  // RULE_06

  // ---------------------------------------------------------------
  // activity qualification
  // ---------------------------------------------------------------
  // going active is immediate; going idle needs a run of idle samples so
  // the brief both-high glitch on every data edge is not read as idle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      active_ff  <= 1'h0;
      idleCnt_ff <= '0;
    end else if (!idleRaw) begin
      active_ff  <= 1'h1;  // RULE_04
      idleCnt_ff <= '0;
    end else if (idleCnt_ff == CW'(IDLE_CYC - 1)) begin
      active_ff  <= 1'h0;  // RULE_04
    end else begin
      idleCnt_ff <= idleCnt_ff + 1'h1;
    end
  end

  assign sense.active = active_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sense_rise_a: assert property (@(posedge mclk) disable iff (!rstn)  // RULE_06
    $rose(active_ff) |-> !$past(idleRaw))
    else $error("activity rose without a driven line");

  sense_sync_a: assert property (@(posedge mclk) disable iff (!rstn)  // RULE_12
    $rose(active_ff) |-> !($past(trueIn, 3) && $past(compIn, 3)))
    else $error("activity rose faster than the synchroniser allows");

endmodule : rpt_sense

// >>> rpt_ctrl.sv
// direction control for a bidirectional differential multipoint repeater
// Function
// RULE_01: master active first enables master-to-slave drive
// RULE_02: slave active first enables slave-to-master drive
// RULE_03: simultaneous activation leaves both directions disabled
// RULE_04: driven line is active, all-idle line inactive
// RULE_05: sense receivers biased high when line undriven
// RULE_06: sense indication is AND of both receivers
// RULE_07: direction follows whichever indication falls first
// RULE_08: after collision, hold off until both idle
// RULE_09: every direction change forces 200 ns off gap
// RULE_10: data transitions never update direction enables
// RULE_11: second side active before enable flags error
// RULE_12: sense inputs pass two-stage synchroniser first
`timescale 1ns/1ps
module rpt_ctrl
  import rpt_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_QUAL_CYC
) (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic mstTrue,
  input  wire logic mstComp,
  input  wire logic slvTrue,
  input  wire logic slvComp,
  output wire logic enM2s,
  output wire logic enS2m,
  output wire logic errFlag
);

  localparam int GW = $clog2(GAP_CYC + 1);

  rpt_sense_if mstSense ();
  rpt_sense_if slvSense ();

  rpt_state_t    state_ff;
  rpt_state_t    nxt_state;
  rpt_state_t    target_ff;
  rpt_state_t    nxt_target;
  logic [GW-1:0] gapCnt_ff;
  logic [GW-1:0] nxt_gapCnt;
  logic          enM2s_ff;
  logic          enS2m_ff;
  logic          errFlag_ff;
  logic          errSet;
  logic          mAct;
  logic          sAct;
  logic          srcAct;
  logic          farAct;

  // ---------------------------------------------------------------
  // sense channels
  // ---------------------------------------------------------------
  // the receiver bias that makes an idle line read high is board-side
  rpt_sense #(.IDLE_CYC(IDLE_CYC)) uMstSense (
    .mclk   (mclk),
    .rstn   (rstn),
    .trueIn (mstTrue),
    .compIn (mstComp),
    .sense  (mstSense.src)
  );

  rpt_sense #(.IDLE_CYC(IDLE_CYC)) uSlvSense (
    .mclk   (mclk),
    .rstn   (rstn),
    .trueIn (slvTrue),
    .compIn (slvComp),
    .sense  (slvSense.src)
  );

  assign mAct   = mstSense.active;
  assign sAct   = slvSense.active;
  assign srcAct = (target_ff == RPT_M2S) ? mAct : sAct;
  assign farAct = (target_ff == RPT_M2S) ? sAct : mAct;

  // ---------------------------------------------------------------
  // direction state machine
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state  = state_ff;
    nxt_target = target_ff;
    nxt_gapCnt = gapCnt_ff;
    errSet     = 1'h0;
    case (state_ff)
      RPT_IDLE: begin
        if (mAct && sAct) begin
          nxt_state = RPT_HOLD;  // RULE_03
          errSet    = 1'h1;
        end else if (mAct) begin
          nxt_state  = RPT_GAP;  // RULE_07
          nxt_target = RPT_M2S;
          nxt_gapCnt = '0;
        end else if (sAct) begin
          nxt_state  = RPT_GAP;  // RULE_07
          nxt_target = RPT_S2M;
          nxt_gapCnt = '0;
        end
      end
      RPT_GAP: begin
        if (target_ff != RPT_HOLD && farAct) begin
          nxt_state = RPT_HOLD;  // RULE_11
          errSet    = 1'h1;
        end else if (target_ff != RPT_HOLD && !srcAct) begin
          nxt_state = RPT_HOLD;
        end else if (gapCnt_ff == GW'(GAP_CYC - 1)) begin
          nxt_state = target_ff;  // RULE_09
        end else begin
          nxt_gapCnt = gapCnt_ff + 1'h1;
        end
      end
      // activity stays high across data edges, so only release is seen
      RPT_M2S: begin
        if (!mAct) begin
          nxt_state  = RPT_GAP;  // RULE_10
          nxt_target = RPT_HOLD;
          nxt_gapCnt = '0;
        end
      end
      RPT_S2M: begin
        if (!sAct) begin
          nxt_state  = RPT_GAP;  // RULE_10
          nxt_target = RPT_HOLD;
          nxt_gapCnt = '0;
        end
      end
      RPT_HOLD: begin
        // our own drive decays on the far side before it reads idle
        if (rpt_both_idle(mAct, sAct)) begin
          nxt_state = RPT_IDLE;  // RULE_08
        end
      end
      default: begin
        nxt_state = RPT_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff  <= RPT_IDLE;
      target_ff <= RPT_HOLD;
      gapCnt_ff <= '0;
    end else begin
      state_ff  <= nxt_state;
      target_ff <= nxt_target;
      gapCnt_ff <= nxt_gapCnt;
    end
  end

  // ---------------------------------------------------------------
  // driver enables and error flag
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enM2s_ff <= 1'h0;
      enS2m_ff <= 1'h0;
    end else begin
      enM2s_ff <= (nxt_state == RPT_M2S);  // RULE_01
      enS2m_ff <= (nxt_state == RPT_S2M);  // RULE_02
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      errFlag_ff <= 1'h0;
    end else if (errSet) begin
      errFlag_ff <= 1'h1;  // RULE_11
    end else if (nxt_state == RPT_IDLE) begin
      errFlag_ff <= 1'h0;
    end
  end

  assign enM2s   = enM2s_ff;
  assign enS2m   = enS2m_ff;
  assign errFlag = errFlag_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam int OFF_MAX = (1 << CNT_W) - 1;

  logic [CNT_W-1:0] offRun_ff;

  // cycles since either enable was last high, saturating
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      offRun_ff <= '0;
    end else if (enM2s_ff || enS2m_ff) begin
      offRun_ff <= '0;
    end else if (offRun_ff != CNT_W'(OFF_MAX)) begin
      offRun_ff <= offRun_ff + 1'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence bothRise;
    state_ff == RPT_IDLE && mAct && sAct;
  endsequence

  sequence allOff;
    !enM2s_ff && !enS2m_ff;
  endsequence

  excl_enable_a: assert property (!(enM2s_ff && enS2m_ff))  // RULE_03
    else $error("both repeater directions enabled");

  coll_off_a: assert property (bothRise |=> errFlag_ff ##0 allOff [*8])  // RULE_03
    else $error("simultaneous activation did not disable both drivers");

  m2s_pick_a: assert property ($rose(enM2s_ff) |-> $past(mAct) && !$past(sAct))  // RULE_01
    else $error("master-to-slave enabled without master activity first");

  s2m_pick_a: assert property ($rose(enS2m_ff) |-> $past(sAct) && !$past(mAct))  // RULE_02
    else $error("slave-to-master enabled without slave activity first");

  gap_len_a: assert property (  // RULE_09
    ($rose(enM2s_ff) || $rose(enS2m_ff)) |-> $past(offRun_ff) >= CNT_W'(GAP_CYC))
    else $error("enable applied before the idle gap elapsed");

  hold_idle_a: assert property (  // RULE_08
    state_ff == RPT_HOLD && !rpt_both_idle(mAct, sAct) |=> state_ff == RPT_HOLD ##0 allOff)
    else $error("collision hold released before both sides idle");

  early_err_a: assert property (  // RULE_11
    state_ff == RPT_GAP && target_ff != RPT_HOLD && farAct |=> errFlag_ff ##0 allOff)
    else $error("second side active during gap not flagged");

  dir_keep_a: assert property (enM2s_ff && mAct |=> enM2s_ff)  // RULE_10
    else $error("master-to-slave enable dropped while master still active");

endmodule : rpt_ctrl

// >>> rpt_seg_model.sv
// two biased cable segments with their sense receiver pairs, seen from the control block
`timescale 1ns/1ps
module rpt_seg_model (
  input  wire logic mstDrv,
  input  wire logic mstDat,
  input  wire logic slvDrv,
  input  wire logic slvDat,
  input  wire logic enM2s,
  input  wire logic enS2m,
  output wire logic mstTrue,
  output wire logic mstComp,
  output wire logic slvTrue,
  output wire logic slvComp
);
  // ---------------------------------------------------------------
  // segment drive
  // ---------------------------------------------------------------
  logic mstOn;
  logic slvOn;
  logic mstLvl;
  logic slvLvl;
  // the repeater pointing into a segment drives it just like a station
  assign mstOn  = mstDrv | enS2m;
  assign slvOn  = slvDrv | enM2s;
  // levels come from the source stations, so a faulty double enable cannot loop
  assign mstLvl = mstDrv ? mstDat : slvDat;
  assign slvLvl = slvDrv ? slvDat : mstDat;

  // ---------------------------------------------------------------
  // sense receivers
  // ---------------------------------------------------------------
  // bias pulls both outputs high on an undriven segment; driving overrides it
  assign mstTrue = mstOn ? mstLvl  : 1'h1;
  assign mstComp = mstOn ? !mstLvl : 1'h1;
  assign slvTrue = slvOn ? slvLvl  : 1'h1;
  assign slvComp = slvOn ? !slvLvl : 1'h1;
endmodule : rpt_seg_model

// >>> testbench.sv
// self-checking bench for the repeater direction control
`timescale 1ns/1ps
module testbench;
  import rpt_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int IDLE_Q = 2;
  logic       mclk;
  logic       rstn;
  logic       mstDrv;
  logic       mstDat;
  logic       slvDrv;
  logic       slvDat;
  logic [3:0] dataCnt_ff;
  wire logic  mstTrue;
  wire logic  mstComp;
  wire logic  slvTrue;
  wire logic  slvComp;
  wire logic  enM2s;
  wire logic  enS2m;
  wire logic  errFlag;
  int         errTotal;
  int         comparisons;

  rpt_seg_model seg_u (.mstDrv(mstDrv), .mstDat(mstDat), .slvDrv(slvDrv), .slvDat(slvDat),
    .enM2s(enM2s), .enS2m(enS2m), .mstTrue(mstTrue), .mstComp(mstComp),
    .slvTrue(slvTrue), .slvComp(slvComp));
  rpt_ctrl #(.IDLE_CYC(IDLE_Q)) dut_u (.mclk(mclk), .rstn(rstn), .mstTrue(mstTrue),
    .mstComp(mstComp), .slvTrue(slvTrue), .slvComp(slvComp), .enM2s(enM2s),
    .enS2m(enS2m), .errFlag(errFlag));

  always #2.5 mclk = ~mclk;
  // data keeps toggling on both stations; only a driven station shows it
  always @(posedge mclk) begin
    dataCnt_ff <= dataCnt_ff + 4'h1;
    mstDat     <= dataCnt_ff[1];
    slvDat     <= dataCnt_ff[2];
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task check(input logic seen, input logic exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task complete_run;
    $display("comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  // one clean bus turn from either side, then release
  task talk(input logic fromMst);
    int n;
    n = 0;
    @(posedge mclk);
    if (fromMst) mstDrv <= 1'h1;
    else slvDrv <= 1'h1;
    repeat (40) @(posedge mclk);
    #1 check(enM2s | enS2m, 1'h0, "enable inside off gap");
    while (!(enM2s | enS2m) && n < 30) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check(enM2s, fromMst, "master to slave enable");
    check(enS2m, !fromMst, "slave to master enable");
    repeat (30) @(posedge mclk);
    #1 check(enM2s | enS2m, 1'h1, "enable lost on data");
    check(errFlag, 1'h0, "error on clean turn");
    @(posedge mclk);
    mstDrv <= 1'h0;
    slvDrv <= 1'h0;
    repeat (IDLE_Q + 6) @(posedge mclk);
    #1 check(enM2s | enS2m, 1'h0, "enable kept after release");
    repeat (100) @(posedge mclk);
    $display("test talk %0d done", fromMst);
  endtask : talk

  // second side joins after lag cycles: same cycle or inside the off gap
  task clash(input int lag);
    logic anyOn;
    anyOn = 1'h0;
    @(posedge mclk);
    mstDrv <= 1'h1;
    repeat (lag) @(posedge mclk);
    slvDrv <= 1'h1;
    repeat (60) begin
      @(posedge mclk);
      #1 anyOn = anyOn | enM2s | enS2m;
    end
    check(anyOn, 1'h0, "enable during clash");
    check(errFlag, 1'h1, "clash not flagged");
    @(posedge mclk);
    mstDrv <= 1'h0;
    repeat (30) begin
      @(posedge mclk);
      #1 anyOn = anyOn | enM2s | enS2m;
    end
    check(anyOn, 1'h0, "enable with one side still driven");
    check(errFlag, 1'h1, "error cleared too early");
    @(posedge mclk);
    slvDrv <= 1'h0;
    repeat (100) @(posedge mclk);
    #1 check(errFlag, 1'h0, "error stuck after idle");
    $display("test clash %0d done", lag);
  endtask : clash

  // a burst that ends inside the off gap must leave both directions off
  task blip;
    logic anyOn;
    anyOn = 1'h0;
    @(posedge mclk);
    mstDrv <= 1'h1;
    repeat (10) @(posedge mclk);
    mstDrv <= 1'h0;
    repeat (60) begin
      @(posedge mclk);
      #1 anyOn = anyOn | enM2s | enS2m;
    end
    check(anyOn, 1'h0, "enable after short burst");
    check(errFlag, 1'h0, "error on short burst");
    $display("test blip done");
  endtask : blip

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk        = 1'h0;
    rstn        = 1'h0;
    mstDrv      = 1'h0;
    slvDrv      = 1'h0;
    mstDat      = 1'h0;
    slvDat      = 1'h0;
    dataCnt_ff  = 4'h0;
    errTotal    = 0;
    comparisons = 0;
    repeat (12) @(posedge mclk);
    rstn <= 1'h1;
    #1 check(enM2s | enS2m | errFlag, 1'h0, "reset values");
    talk(1'h1);
    talk(1'h0);
    clash(0);
    clash(10);
    blip;
    talk(1'h1);
    complete_run;
  end

  // the whole sequence needs about 1030 cycles
  initial begin
    #50000;
    errTotal++;
    $display("wrong value at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule : testbench
